//--- testbench/dspc_ctrl_monitor.sv
/* checker of phase order, integration length and apb answers.
   assumes it is bound to dspc_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module dspc_ctrl_monitor #(
  parameter int CNT_W = dspc_pkg::CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire dspc_pkg::dspc_apb_req_t apb_req_i,
  input wire dspc_pkg::dspc_apb_rsp_t apb_rsp_o,
  input wire logic comp_out_i,
  input wire logic phase_a_o,
  input wire logic phase_b_o,
  input wire logic chip_sel_o
);
  // ==========================================
  // helper logic
  logic [1:0] code;
  logic [CNT_W-1:0] int_cnt;
  logic [31:0] run;
  logic acc;
  assign code = {phase_a_o, phase_b_o};
  assign acc = apb_req_i.psel && apb_req_i.penable;
  // shadow of the integrate count; a write during integration would break it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) int_cnt <= dspc_pkg::RST_INT_COUNT[CNT_W-1:0];
    else if (acc && apb_req_i.pwrite && apb_req_i.paddr == dspc_pkg::OFS_INT_COUNT)
      int_cnt <= apb_req_i.pwdata[CNT_W-1:0];
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || code != dspc_pkg::PH_INTEG) run <= 32'h0;
    else run <= run + 32'h1;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // assertions
  a_integ_to_ramp: assert property (code == 2'h2 && chip_sel_o |=> code inside {2'h2, 2'h3})
    else $error("integration left other than into ramp");
  a_null_to_integ: assert property (code == 2'h1 |=> code inside {2'h1, 2'h2})
    else $error("null phase left other than into integration");
  a_ramp_to_clear: assert property (code == 2'h3 && chip_sel_o |=> code inside {2'h3, 2'h0})
    else $error("ramp left other than into clear");
  a_clear_to_null: assert property (code == 2'h0 |=> code inside {2'h0, 2'h1})
    else $error("clear left other than into null");
  a_clear_hold: assert property ((code == 2'h0 && !comp_out_i)[*2] |=> code == 2'h0)
    else $error("clear left while comparator low");
  a_idle_when_off: assert property ((!chip_sel_o)[*2] |-> code == 2'h1)
    else $error("phase not null while powered down");
  a_integ_len: assert property (code != 2'h2 && $past(code) == 2'h2 |-> run == 32'(int_cnt))
    else $error("integration length differs from count");
  a_apb_mapped: assert property (acc && apb_req_i.paddr <= 8'h18 && apb_req_i.paddr[1:0] == 2'h0
    |-> apb_rsp_o.pready && !apb_rsp_o.pslverr)
    else $error("mapped access not answered cleanly");
  a_apb_unmapped: assert property (acc && apb_req_i.paddr > 8'h18
    |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // dspc_ctrl_monitor
bind dspc_ctrl dspc_ctrl_monitor #(.CNT_W(CNT_W)) i_mon (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .comp_out_i(comp_out_i),
  .phase_a_o(phase_a_o), .phase_b_o(phase_b_o), .chip_sel_o(chip_sel_o));
`default_nettype wire

//--- testbench/dspc_dev_model.sv
/* behavioural analog processor: comparator level from the phase code.
   assumes pins are sampled on the controller's clock. */
`timescale 1ns/1ps
`default_nettype none
module dspc_dev_model (
  input wire logic clk_sys_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic chip_sel_i,
  input wire logic pos_i,
  input wire logic [15:0] ramp_len_i,
  input wire logic [15:0] clear_len_i,
  output logic comp_out_o
);
  logic [1:0] code;
  logic [1:0] prev = 2'h1;
  logic [15:0] cnt = 16'h0;
  logic [15:0] age;
  logic tgl = 1'b0;
  assign code = {phase_a_i, phase_b_i};
  assign age = (code == prev) ? cnt : 16'h0;
  always_ff @(posedge clk_sys_i) begin
    prev <= code;
    cnt <= age + 16'h1;
    tgl <= !tgl;
  end
  // undefined levels toggle so a controller reading them is caught
  always_comb begin
    if (!chip_sel_i) comp_out_o = tgl;
    else case (code)
      2'h1: comp_out_o = tgl;
      2'h2: comp_out_o = pos_i;
      2'h3: comp_out_o = age < ramp_len_i;
      default: comp_out_o = age >= clear_len_i;
    endcase
  end
endmodule // dspc_dev_model
`default_nettype wire

//--- testbench/test_dspc_ctrl.sv
/* self-checking bench of the phase controller over apb.
   assumes the device model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_dspc_ctrl;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  dspc_pkg::dspc_apb_req_t req = '0;
  dspc_pkg::dspc_apb_rsp_t rsp;
  logic comp, pa, pb, cs, e;
  logic pos = 1'b1;
  logic [15:0] mag = 16'h000A;
  logic [15:0] seq = 16'h0;
  logic [1:0] last = 2'h1;
  logic [31:0] q;
  int mismatches = 0;
  int check_count = 0;
  dspc_ctrl i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .comp_out_i(comp), .phase_a_o(pa), .phase_b_o(pb), .chip_sel_o(cs));
  dspc_dev_model i_dev (.clk_sys_i(clk_sys_i), .phase_a_i(pa), .phase_b_i(pb),
    .chip_sel_i(cs), .pos_i(pos), .ramp_len_i(mag), .clear_len_i(16'h0003),
    .comp_out_o(comp));
  initial begin
    forever begin
      #25;
      clk_sys_i = !clk_sys_i;
    end
  end
  // ==========================================
  // phase change history, two bits per change
  always @(negedge clk_sys_i) begin
    if ({pa, pb} != last) begin
      seq <= {seq[13:0], pa, pb};
      last <= {pa, pb};
    end
  end
  // ==========================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_rng(input string n, input logic [31:0] lo, input logic [31:0] g);
    check_count++;
    if ((g >= lo && g <= lo + 32'h4) !== 1'b1) begin
      mismatches++;
      $display("Error %s expected %h to %h seen %h", n, lo, lo + 32'h4, g);
    end
  endtask
  // request stands until the rising edge that samples pready high; data is taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys_i);
      if (rsp.pready === 1'b1) begin
        q = rsp.prdata;
        e = rsp.pslverr;
        break;
      end
    end
    req <= '0;
    if (k == 20) begin
      chk("pready", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, dspc_pkg::OFS_STATUS, 32'h0);
      if (q[b] === v) break;
    end
    if (k == 300) begin
      chk("status poll", 32'(v), 32'(q[b]));
      end_of_test();
    end
  endtask
  task automatic conv(input logic p, input logic [15:0] m, input logic ov);
    int k;
    pos <= p;
    mag <= m;
    seq <= 16'h0;
    apb(1'b1, dspc_pkg::OFS_CTRL, 32'h5);
    poll(dspc_pkg::STAT_DONE_BIT, 1'b1);
    apb(1'b0, dspc_pkg::OFS_RESULT, 32'h0);
    chk("sign", 32'(p), 32'(q[31]));
    chk("overrange", 32'(ov), 32'(q[30]));
    if (!ov) chk_rng("ramp count", 32'(m), {8'h0, q[23:0]});
    for (k = 0; k < 100 && {pa, pb} !== 2'h1; k++) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk("phase order", 32'hB1, {24'h0, seq[7:0]});
    $display("test conversion sign %0d done", p);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    chk("pins at reset", 32'h1, {29'h0, cs, pa, pb});
    rd("ctrl", dspc_pkg::OFS_CTRL, 32'h0);
    rd("status", dspc_pkg::OFS_STATUS, 32'h10);
    rd("int count", dspc_pkg::OFS_INT_COUNT, 32'h10000);
    rd("null count", dspc_pkg::OFS_NULL_COUNT, 32'h10000);
    rd("max count", dspc_pkg::OFS_MAX_COUNT, 32'h30000);
    rd("clear max", dspc_pkg::OFS_CLEAR_MAX, 32'h4E20);
    apb(1'b1, 8'h1C, 32'hFFFF);
    rd("unmapped", 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    $display("test registers done");
    apb(1'b1, dspc_pkg::OFS_INT_COUNT, 32'h8);
    apb(1'b1, dspc_pkg::OFS_NULL_COUNT, 32'h8);
    apb(1'b1, dspc_pkg::OFS_MAX_COUNT, 32'h28);
    apb(1'b1, dspc_pkg::OFS_CLEAR_MAX, 32'h40);
    conv(1'b1, 16'h000A, 1'b0);
    conv(1'b0, 16'h0005, 1'b0);
    conv(1'b1, 16'h00C8, 1'b1);
    rd("status after overrange", dspc_pkg::OFS_STATUS, 32'h16);
    seq <= 16'h0;
    apb(1'b1, dspc_pkg::OFS_CTRL, 32'h6);
    for (int k = 0; k < 800 && seq !== 16'hB1B1; k++) @(posedge clk_sys_i);
    chk("continuous", 32'hB1B1, {16'h0, seq});
    apb(1'b1, dspc_pkg::OFS_CTRL, 32'h4);
    poll(dspc_pkg::STAT_BUSY_BIT, 1'b0);
    apb(1'b1, dspc_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk("powered down", 32'h1, {29'h0, cs, pa, pb});
    $display("test continuous and power done");
    end_of_test();
  end
endmodule // test_dspc_ctrl
`default_nettype wire

//--- verilog/dspc_apb_regs.sv
/*
  apb slave with control and count registers of the phase controller.
  assumes a single-clock apb master; answers with zero wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module dspc_apb_regs #(
  parameter int CNT_W = dspc_pkg::CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire dspc_pkg::dspc_apb_req_t req_i,
  output dspc_pkg::dspc_apb_rsp_t rsp_o,
  input wire logic [31:0] status_i,
  input wire logic [31:0] result_i,
  output logic start_o,
  output logic cont_o,
  output logic power_o,
  output logic [CNT_W-1:0] int_count_o,
  output logic [CNT_W-1:0] null_count_o,
  output logic [CNT_W-1:0] max_count_o,
  output logic [CNT_W-1:0] clear_max_o
);
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic hit;

  assign wr_en = req_i.psel & req_i.penable & req_i.pwrite;
  assign rd_en = req_i.psel & req_i.penable & ~req_i.pwrite;

  // ==========================================================
  // writes
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      start_o <= 1'b0;
      cont_o <= 1'b0;
      power_o <= 1'b0;
      int_count_o <= dspc_pkg::RST_INT_COUNT;
      null_count_o <= dspc_pkg::RST_NULL_COUNT;
      max_count_o <= dspc_pkg::RST_MAX_COUNT;
      clear_max_o <= dspc_pkg::RST_CLEAR_MAX;
    end else begin
      start_o <= 1'b0;
      if (wr_en) begin
        if (req_i.paddr == dspc_pkg::OFS_CTRL) begin
          start_o <= req_i.pwdata[dspc_pkg::CTRL_START_BIT];
          cont_o <= req_i.pwdata[dspc_pkg::CTRL_CONT_BIT];
          power_o <= req_i.pwdata[dspc_pkg::CTRL_POWER_BIT];
        end else if (req_i.paddr == dspc_pkg::OFS_INT_COUNT) begin
          int_count_o <= req_i.pwdata[CNT_W-1:0];
        end else if (req_i.paddr == dspc_pkg::OFS_NULL_COUNT) begin
          null_count_o <= req_i.pwdata[CNT_W-1:0];
        end else if (req_i.paddr == dspc_pkg::OFS_MAX_COUNT) begin
          max_count_o <= req_i.pwdata[CNT_W-1:0];
        end else if (req_i.paddr == dspc_pkg::OFS_CLEAR_MAX) begin
          clear_max_o <= req_i.pwdata[CNT_W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // read decode
  always_comb begin
    rd_data = 32'h00000000;
    hit = 1'b1;
    if (req_i.paddr == dspc_pkg::OFS_CTRL) begin
      rd_data[dspc_pkg::CTRL_CONT_BIT] = cont_o;
      rd_data[dspc_pkg::CTRL_POWER_BIT] = power_o;
    end else if (req_i.paddr == dspc_pkg::OFS_STATUS) begin
      rd_data = status_i;
    end else if (req_i.paddr == dspc_pkg::OFS_INT_COUNT) begin
      rd_data[CNT_W-1:0] = int_count_o;
    end else if (req_i.paddr == dspc_pkg::OFS_NULL_COUNT) begin
      rd_data[CNT_W-1:0] = null_count_o;
    end else if (req_i.paddr == dspc_pkg::OFS_MAX_COUNT) begin
      rd_data[CNT_W-1:0] = max_count_o;
    end else if (req_i.paddr == dspc_pkg::OFS_RESULT) begin
      rd_data = result_i;
    end else if (req_i.paddr == dspc_pkg::OFS_CLEAR_MAX) begin
      rd_data[CNT_W-1:0] = clear_max_o;
    end else begin
      hit = 1'b0;
    end
  end

  // unmapped addresses answer with pslverr and zero data
  always_comb begin
    rsp_o.pready = 1'b1;
    rsp_o.pslverr = req_i.psel & req_i.penable & ~hit;
    rsp_o.prdata = (rd_en & hit) ? rd_data : 32'h00000000;
  end
endmodule // dspc_apb_regs
`default_nettype wire

//--- verilog/dspc_ctrl.sv
/*
  dual-slope phase controller top: drives phase pins a/b and chip select,
  times the integrate, ramp and clear phases and reports over apb.
  assumes the comparator input is synchronous to clk_sys_i (20 MHz).
*/
`timescale 1ns/1ps
`default_nettype none
module dspc_ctrl #(
  parameter int CNT_W = dspc_pkg::CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire dspc_pkg::dspc_apb_req_t apb_req_i,
  output dspc_pkg::dspc_apb_rsp_t apb_rsp_o,
  input wire logic comp_out_i,
  output logic phase_a_o,
  output logic phase_b_o,
  output logic chip_sel_o
);
  typedef enum {
    ST_IDLE,
    ST_NULL,
    ST_INTEG,
    ST_RAMP,
    ST_CLEAR
  } dspc_state_t;

  dspc_state_t state;
  logic start;
  logic cont;
  logic power;
  logic [CNT_W-1:0] int_count;
  logic [CNT_W-1:0] null_count;
  logic [CNT_W-1:0] max_count;
  logic [CNT_W-1:0] clear_max;
  logic [CNT_W-1:0] cnt;
  logic comp_fall;
  logic comp_lvl;
  logic sign;
  logic ovr;
  logic clr_to;
  logic done;
  logic [CNT_W-1:0] result;
  logic [31:0] status_word;
  logic [31:0] result_word;
  logic [1:0] next_code;

  function automatic logic [1:0] phase_code(input dspc_state_t s);
    case (s)
      ST_INTEG: phase_code = dspc_pkg::PH_INTEG;
      ST_RAMP: phase_code = dspc_pkg::PH_RAMP;
      ST_CLEAR: phase_code = dspc_pkg::PH_CLEAR;
      default: phase_code = dspc_pkg::PH_NULL;
    endcase
  endfunction

  // ==========================================================
  // register file
  dspc_apb_regs #(.CNT_W(CNT_W)) u_regs (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .req_i(apb_req_i),
    .rsp_o(apb_rsp_o),
    .status_i(status_word),
    .result_i(result_word),
    .start_o(start),
    .cont_o(cont),
    .power_o(power),
    .int_count_o(int_count),
    .null_count_o(null_count),
    .max_count_o(max_count),
    .clear_max_o(clear_max)
  );

  dspc_fall_det u_fall (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .level_i(comp_out_i),
    .fall_o(comp_fall),
    .level_o(comp_lvl)
  );

  always_comb begin
    status_word = 32'h00000000;
    // the null phase of a single conversion is part of the work, so it reads busy too
    status_word[dspc_pkg::STAT_BUSY_BIT] = (state != ST_IDLE);
    status_word[dspc_pkg::STAT_DONE_BIT] = done;
    status_word[dspc_pkg::STAT_OVR_BIT] = ovr;
    status_word[dspc_pkg::STAT_CLR_TO_BIT] = clr_to;
    status_word[dspc_pkg::STAT_PHASE_LSB +: 2] = phase_code(state);
    result_word = 32'h00000000;
    result_word[CNT_W-1:0] = result;
    result_word[dspc_pkg::RES_SIGN_BIT] = sign;
    result_word[dspc_pkg::RES_OVR_BIT] = ovr;
  end

  // ==========================================================
  // phase sequencer
  // idle also drives the null code so the device rests in offset null
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (!power) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (start || cont) begin
            state <= ST_NULL;
          end
        end
        ST_NULL: begin
          // comparator ignored here, only the count ends the phase
          if (cnt >= null_count - 1'b1) begin
            cnt <= '0;
            state <= ST_INTEG;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_INTEG: begin
          if (cnt >= int_count - 1'b1) begin
            cnt <= '0;
            state <= ST_RAMP; // code 10 straight to 11
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_RAMP: begin
          // count from entry into ramp, one cycle before the pin code changes, up to the comparator fall
          if (comp_fall || cnt >= max_count) begin
            cnt <= '0;
            state <= ST_CLEAR;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_CLEAR: begin
          // held until comparator is high again, bounded by a timeout
          if (comp_lvl || cnt >= clear_max) begin
            cnt <= '0;
            state <= cont ? ST_NULL : ST_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sign, result and flags
  // count is raw; comparator delay trimming is left to software
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sign <= 1'b0;
      ovr <= 1'b0;
      clr_to <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      if (start) begin
        done <= 1'b0;
      end
      if (state == ST_INTEG && cnt >= int_count - 1'b1) begin
        sign <= comp_lvl; // last integrate cycle holds the polarity
      end
      if (state == ST_RAMP && (comp_fall || cnt >= max_count)) begin
        result <= cnt;
        ovr <= ~comp_fall;
        done <= 1'b1;
      end
      if (state == ST_CLEAR && (comp_lvl || cnt >= clear_max)) begin
        clr_to <= ~comp_lvl;
      end
    end
  end

  // ==========================================================
  // pins, registered; code a is msb, b is lsb
  always_comb begin
    next_code = phase_code(state);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      phase_a_o <= dspc_pkg::PH_NULL[1];
      phase_b_o <= dspc_pkg::PH_NULL[0];
      chip_sel_o <= 1'b0;
    end else begin
      phase_a_o <= next_code[1];
      phase_b_o <= next_code[0];
      chip_sel_o <= power;
    end
  end
endmodule // dspc_ctrl
`default_nettype wire

//--- verilog/dspc_fall_det.sv
/*
  falling-edge detector for the comparator output.
  assumes the comparator input is already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dspc_fall_det (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic level_i,
  output logic fall_o,
  output logic level_o
);
  logic prev;

  // ==========================================================
  // edge
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prev <= 1'b1;
    end else begin
      prev <= level_i;
    end
  end

  assign fall_o = prev & ~level_i;
  assign level_o = level_i;
endmodule // dspc_fall_det
`default_nettype wire

//--- verilog/dspc_pkg.sv
/*
  constants, types and register map of the dual-slope phase controller.
  assumes a 20 MHz system clock and an apb master in software's reach.
*/
package dspc_pkg;

  // ==========================================================
  // phase codes
  localparam logic [1:0] PH_CLEAR = 2'h0;
  localparam logic [1:0] PH_NULL = 2'h1;
  localparam logic [1:0] PH_INTEG = 2'h2;
  localparam logic [1:0] PH_RAMP = 2'h3;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_COUNT = 8'h08;
  localparam logic [7:0] OFS_NULL_COUNT = 8'h0C;
  localparam logic [7:0] OFS_MAX_COUNT = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_CLEAR_MAX = 8'h18;

  // ctrl fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_POWER_BIT = 2;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_OVR_BIT = 2;
  localparam int STAT_CLR_TO_BIT = 3;
  localparam int STAT_PHASE_LSB = 4;
  // result fields
  localparam int RES_SIGN_BIT = 31;
  localparam int RES_OVR_BIT = 30;

  // ==========================================================
  // reset values, counts in clk_sys_i cycles
  localparam logic [23:0] RST_INT_COUNT = 24'h010000;
  localparam logic [23:0] RST_NULL_COUNT = 24'h010000;
  localparam logic [23:0] RST_MAX_COUNT = 24'h030000;
  localparam logic [23:0] RST_CLEAR_MAX = 24'h004E20;
  localparam int CNT_W = 24;

  // ==========================================================
  // apb request and answer carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dspc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dspc_apb_rsp_t;

  // pins to the analog processor
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic chip_sel;
  } dspc_pins_t;

endpackage
